/* File: design/odd_clk_div.sv */
// divide-by-three or divide-by-five clock divider with glitch-free enable
// Function
// - after enable rises, output starts only once an input rising then falling edge have passed.
// - after enable falls, output stops only after an input rising edge and a completed output fall.
// - the last output high phase on disable always has its full width, for both ratios.
// - the divider advances on both rising and falling edges of the input clock.
// - in divide-by-three the output falls on the falling edge of the second input cycle.
// - in divide-by-five the output falls on the falling edge of the third input cycle.
// - the enable register resets asserted, but after reset it follows the enable input every cycle.
// - while master clear is low the true output is low and the complement high.
// - with clear released and enable high, a low ratio select divides by three.
// - with clear released and enable high, a high ratio select divides by five.
// - with clear released and enable low, the true output is low and the complement high.
`timescale 1ns/10ps
module odd_clk_div (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic clk_in,
  input  wire logic master_clear_n,
  input  wire logic enable,
  input  wire logic div_sel,
  output logic      q_r,
  output logic      qn_r
);
  logic                      rst_s1_r;
  logic                      rst_s2_r;
  logic                      rst;
  logic                      rise_ev;
  logic                      fall_ev;
  logic                      edge_ev;
  logic                      en_r;
  logic                      ratio_r;
  logic [div_pkg::PH_W-1:0]  ph_r;
  logic [div_pkg::PH_W-1:0]  ph_inc;
  logic [div_pkg::PH_W-1:0]  hi_cnt_r;
  div_pkg::gate_e            state_r;
  localparam int unsigned    PH_W = div_pkg::PH_W;

  function automatic logic [div_pkg::PH_W-1:0] half_n(input logic sel);
    half_n = sel ? div_pkg::DIV_HI_N : div_pkg::DIV_LO_N;
  endfunction : half_n

  // last half-cycle index of a period, always a falling-edge slot
  function automatic logic [div_pkg::PH_W-1:0] last_ph(input logic sel);
    last_ph = PH_W'((half_n(sel) << 1) - 4'h1);
  endfunction : last_ph

  // release is synchronised, assertion of reset stays asynchronous
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst = ~rst_s2_r;

  edge_pulse u_edge (
    .clk    (clk),
    .rst    (rst),
    .sig    (clk_in),
    .rise_r (rise_ev),
    .fall_r (fall_ev)
  );

  // clk_in is sampled on clk, so outputs trail its edges by about two cycles
  // both input edges step the divider so odd ratios land on half cycles
  assign edge_ev = rise_ev | fall_ev;
  assign ph_inc  = ph_r + 4'h1;

  // resets high, then follows the enable input from the first clock after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r <= div_pkg::EN_RST_VAL;
    end else begin
      en_r <= enable;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= div_pkg::ST_IDLE;
      ph_r    <= '0;
      ratio_r <= 1'b0;
      q_r     <= div_pkg::Q_RST_VAL;
      qn_r    <= ~div_pkg::Q_RST_VAL;
    end else if (!master_clear_n) begin
      state_r <= div_pkg::ST_IDLE;
      ph_r    <= '0;
      q_r     <= 1'b0;
      qn_r    <= 1'b1;
    end else begin
      unique case (state_r)
        div_pkg::ST_IDLE: begin
          if (en_r) begin
            state_r <= div_pkg::ST_ARM_RISE;
          end
        end
        div_pkg::ST_ARM_RISE: begin
          if (!en_r) begin
            state_r <= div_pkg::ST_IDLE;
          end else if (rise_ev) begin
            state_r <= div_pkg::ST_ARM_FALL;
          end
        end
        div_pkg::ST_ARM_FALL: begin
          if (!en_r) begin
            state_r <= div_pkg::ST_IDLE;
          end else if (fall_ev) begin
            // parked on the last slot so the next rising edge opens a period
            state_r <= div_pkg::ST_RUN;
            ratio_r <= div_sel;
            ph_r    <= last_ph(div_sel);
          end
        end
        div_pkg::ST_RUN: begin
          if (edge_ev) begin
            if (ph_r == last_ph(ratio_r)) begin
              // gating only at a period boundary keeps every pulse whole
              if (en_r) begin
                ph_r    <= '0;
                ratio_r <= div_sel;
                q_r     <= 1'b1;
                qn_r    <= 1'b0;
              end else begin
                state_r <= div_pkg::ST_IDLE;
              end
            end else begin
              ph_r <= ph_inc;
              if (ph_inc == half_n(ratio_r)) begin
                q_r  <= 1'b0;
                qn_r <= 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // assertion helper: input edges counted while the output is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_cnt_r <= '0;
    end else if (!q_r) begin
      hi_cnt_r <= '0;
    end else if (edge_ev) begin
      hi_cnt_r <= hi_cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_CLEAR_FORCES_LOW: assert property (
    !master_clear_n |=> !q_r && qn_r) else $error("output not forced low by clear");
  AST_CLEAR_RESTARTS: assert property (
    !master_clear_n |=> state_r == div_pkg::ST_IDLE && ph_r == '0)
    else $error("count not restarted after clear");
  AST_COMPLEMENT: assert property (
    qn_r == ~q_r) else $error("outputs not complementary");
  AST_IDLE_LOW: assert property (
    state_r != div_pkg::ST_RUN |-> !q_r) else $error("output high while disabled");
  AST_START_SEQ: assert property (
    state_r == div_pkg::ST_IDLE ##1 state_r == div_pkg::ST_RUN |-> 1'b0)
    else $error("run entered without edge sequence");
  AST_RISE_ON_RISE: assert property (
    $rose(q_r) |-> $past(rise_ev)) else $error("output rose off an input rising edge");
  AST_DIV3_FALL: assert property (
    $fell(q_r) && $past(master_clear_n) && !ratio_r
    |-> ph_r == div_pkg::DIV_LO_N && $past(fall_ev))
    else $error("divide by three fell at wrong edge");
  AST_DIV5_FALL: assert property (
    $fell(q_r) && $past(master_clear_n) && ratio_r
    |-> ph_r == div_pkg::DIV_HI_N && $past(fall_ev))
    else $error("divide by five fell at wrong edge");
  AST_STOP_WHOLE: assert property (
    state_r == div_pkg::ST_RUN ##1 state_r == div_pkg::ST_IDLE && $past(master_clear_n)
    |-> !q_r && $past(rise_ev)) else $error("disable cut a pulse");
  AST_RATIO_TAKEN: assert property (
    $rose(q_r) |-> ratio_r == $past(div_sel)) else $error("ratio select not applied");

  // arming order: a rising then a falling input edge before the first period
  AST_RUN_ENTRY: assert property (
    state_r != div_pkg::ST_RUN ##1 state_r == div_pkg::ST_RUN
    |-> $past(state_r) == div_pkg::ST_ARM_FALL && $past(fall_ev))
    else $error("run entered without a falling input edge");
  AST_ARM_ORDER: assert property (
    state_r == div_pkg::ST_ARM_RISE && rise_ev && en_r && master_clear_n
    |=> state_r == div_pkg::ST_ARM_FALL) else $error("arming missed a rising edge");
  AST_ARM_RISE_WAITS: assert property (
    state_r == div_pkg::ST_ARM_RISE && !rise_ev && en_r && master_clear_n
    |=> state_r == div_pkg::ST_ARM_RISE) else $error("arming left before a rising edge");
  AST_ARM_FALL_WAITS: assert property (
    state_r == div_pkg::ST_ARM_FALL && !fall_ev && en_r && master_clear_n
    |=> state_r == div_pkg::ST_ARM_FALL) else $error("arming left before a falling edge");
  AST_EN_OFF_STAYS: assert property (
    state_r == div_pkg::ST_IDLE && !en_r |=> state_r == div_pkg::ST_IDLE)
    else $error("divider armed while disabled");

  // gating only at a period end, with whole pulses
  AST_DISABLE_IDLE: assert property (
    state_r == div_pkg::ST_RUN && edge_ev && ph_r == last_ph(ratio_r) && !en_r
    && master_clear_n |=> state_r == div_pkg::ST_IDLE && !q_r)
    else $error("disable not taken at period end");
  AST_HIGH_WIDTH: assert property (
    $fell(q_r) && $past(master_clear_n) |-> hi_cnt_r == half_n(ratio_r))
    else $error("high phase not of full width");

  // output moves only on input edges, ratio only at period start
  AST_STABLE_OFF_EDGE: assert property (
    !edge_ev && master_clear_n |=> $stable(q_r))
    else $error("output moved off an input edge");
  AST_PH_RANGE: assert property (
    state_r == div_pkg::ST_RUN |-> ph_r <= last_ph(ratio_r))
    else $error("phase count out of range");
  AST_WRAP_AT_ZERO: assert property (
    $rose(q_r) |-> ph_r == '0) else $error("period opened at a nonzero phase");
  AST_RATIO_HELD: assert property (
    state_r == div_pkg::ST_RUN && !(edge_ev && ph_r == last_ph(ratio_r))
    |=> $stable(ratio_r)) else $error("ratio changed in mid period");
endmodule : odd_clk_div

/* File: design/div_pkg.sv */
// constants and types shared by the odd-ratio clock divider
package div_pkg;
  localparam int unsigned PH_W       = 4;
  localparam logic [3:0]  DIV_LO_N   = 4'h3;
  localparam logic [3:0]  DIV_HI_N   = 4'h5;
  localparam logic        EN_RST_VAL = 1'b1;
  localparam logic        Q_RST_VAL  = 1'b0;
  typedef enum logic [1:0] {ST_IDLE, ST_ARM_RISE, ST_ARM_FALL, ST_RUN} gate_e;
endpackage : div_pkg

/* File: design/edge_pulse.sv */
// rising and falling edge pulses of a sampled clock input
`timescale 1ns/10ps
module edge_pulse (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sig,
  output logic      rise_r,
  output logic      fall_r
);
  logic sig_r;
  logic armed_r;

  // no pulse off the first sample: the pin level before reset is unknown
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sig_r   <= 1'b0;
      armed_r <= 1'b0;
      rise_r  <= 1'b0;
      fall_r  <= 1'b0;
    end else begin
      sig_r   <= sig;
      armed_r <= 1'b1;
      rise_r  <= armed_r & sig & ~sig_r;
      fall_r  <= armed_r & ~sig & sig_r;
    end
  end
endmodule : edge_pulse

/* File: bench/clk_src.sv */
// upstream clock source feeding the divider
`timescale 1ns/10ps
module clk_src #(
  parameter int HP = 4
) (
  input  wire logic clk,
  output logic      clk_in
);
  int cnt;
  // free running input clock, so no idle level to model
  initial begin
    clk_in = 1'b0;
    cnt    = 0;
    forever begin
      @(negedge clk);
      cnt++;
      if (cnt == HP) begin
        cnt    = 0;
        clk_in = ~clk_in;
      end
    end
  end
endmodule : clk_src

/* File: bench/tb_odd_clk_div.sv */
// self-checking bench for the odd-ratio clock divider
`timescale 1ns/10ps
module tb_odd_clk_div;
  localparam int HP = 4;
  logic clk, rstn, clk_in, master_clear_n, enable, div_sel, q, qn;
  int   errors, comparisons, cyc;
  clk_src #(.HP(HP)) clk_src_i (.clk(clk), .clk_in(clk_in));
  odd_clk_div odd_clk_div_i (.clk(clk), .rstn(rstn), .clk_in(clk_in),
    .master_clear_n(master_clear_n), .enable(enable), .div_sel(div_sel), .q_r(q), .qn_r(qn));
  task automatic close_out;
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_num(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_num
  // counts cycles while q holds v, complement checked on the way
  task automatic width(input logic v, output int n);
    n = 0;
    while (q === v && n < 300) begin
      chk_bit(qn, ~v);
      @(negedge clk);
      n++;
    end
  endtask : width
  task automatic t_ratio(input logic s);
    int n;
    div_sel = s;
    repeat (2) begin
      width(1'b1, n);
      width(1'b0, n);
    end
    width(1'b1, n);
    chk_num(n, (s ? 5 : 3) * HP);
    width(1'b0, n);
    chk_num(n, (s ? 5 : 3) * HP);
  endtask : t_ratio
  // disable lands right after a rising output edge
  task automatic t_gate(input logic s);
    int n;
    t_ratio(s);
    enable = 1'b0;
    width(1'b1, n);
    chk_num(n, (s ? 5 : 3) * HP);
    repeat (12 * HP) begin
      @(negedge clk);
      chk_bit(q, 1'b0);
    end
    enable = 1'b1;
    width(1'b0, n);
    chk_num(int'(n > 2 * HP), 1);
    width(1'b1, n);
    chk_num(n, (s ? 5 : 3) * HP);
  endtask : t_gate
  task automatic t_clear;
    int n;
    t_ratio(1'b0);
    master_clear_n = 1'b0;
    div_sel        = 1'b1;
    repeat (3 * HP) @(negedge clk);
    chk_bit(q, 1'b0);
    chk_bit(qn, 1'b1);
    master_clear_n = 1'b1;
    width(1'b0, n);
    width(1'b1, n);
    chk_num(n, 5 * HP);
  endtask : t_clear
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, the whole run needs about 700 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    rstn           = 1'b0;
    master_clear_n = 1'b1;
    enable         = 1'b1;
    div_sel        = 1'b0;
    repeat (10) @(negedge clk);
    chk_bit(q, 1'b0);
    chk_bit(qn, 1'b1);
    rstn = 1'b1;
    t_ratio(1'b0);
    t_ratio(1'b1);
    t_gate(1'b0);
    t_gate(1'b1);
    t_clear;
    close_out;
  end
endmodule : tb_odd_clk_div
